//--- hw/mcc_top.sv
// Functional notes
// RULE_01 - Collision rises while the line shows receive activity during transmit enable.
// RULE_02 - At 10 Mb/s receive activity comes from the unsquelched line detector.
// RULE_03 - At 100 Mb/s a symbol with two non-adjacent zeros marks receive activity.
// RULE_04 - Collision is not aligned to the data clocks and the consumer synchronises it.
// RULE_05 - Full duplex holds collision low at all times.
// RULE_06 - A heartbeat collision pulse follows transmit unless the suppress bit is set; the code sends it only at 10 Mb/s in half-duplex node mode.
// RULE_07 - Half-duplex node mode raises carrier sense on receive or transmit activity.
// RULE_08 - Full-duplex or repeater mode raises carrier sense on receive activity only.
// RULE_09 - Carrier sense is not aligned to the data clocks and the consumer synchronises it.
// RULE_10 - The station manager makes the management clock, which this block only samples.
// RULE_11 - The management data line is shared and this block drives it only for read data; the code also drives the second turnaround bit low.
// RULE_12 - Every drive and sample of management data happens at a management clock edge.
// RULE_13 - Collision and carrier sense fall as soon as their causes end, with no latching.
// RULE_14 - The management data driver is off outside the read-data bit periods; the code also turns it on for the second turnaround bit.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "mcc_map.svh"

module mcc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_en,
    input wire logic rx_unsq_act,
    input wire logic [`MCC_SYM_W-1:0] rx_sym,
    input wire logic rx_sym_vld,
    output logic col,
    output logic crs,
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    mcc_pkg::mcc_state_t s;
    mcc_pkg::mcc_state_t n;
    logic [3:0] pin_s;
    logic sym_act;
    logic tx;
    logic act;
    logic mdc_s;
    logic mdio_s;
    logic mdc_rise;

    function automatic logic [7:0] adr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : adr

    // ------------------------------------------------------------------
    // pin synchronisers and symbol activity
    // ------------------------------------------------------------------
    mcc_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({mdio_i, mdc, rx_unsq_act, tx_en}),
        .q(pin_s)
    );

    mcc_sym_det u_sym (
        .clk(clk),
        .rst_n(rst_n),
        .sym(rx_sym),
        .sym_vld(rx_sym_vld),
        .act(sym_act)
    );

    assign tx = pin_s[0];
    assign act = s.spd ? sym_act : pin_s[1]; // [RULE_02] [RULE_03]
    assign mdc_s = pin_s[2]; // [RULE_10]
    assign mdio_s = pin_s[3];
    assign mdc_rise = mdc_s && !s.mdc_d; // [RULE_12]

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n = s;
        n.tx_d = tx;
        n.mdc_d = mdc_s;

        // collision and carrier sense, recomputed every cycle
        n.col = !s.fdx && ((tx && act) // [RULE_01] [RULE_05] [RULE_13]
            || (s.hb == mcc_pkg::HB_PULSE && !s.hb_sup)); // [RULE_06]
        n.crs = act || (tx && !s.fdx && !s.rep); // [RULE_07] [RULE_08]

        // heartbeat after each 10 Mb/s half-duplex node transmission
        unique case (s.hb)
            mcc_pkg::HB_IDLE:
            begin
                if (s.tx_d && !tx && !s.fdx && !s.rep && !s.spd
                    && !s.hb_sup)
                begin
                    n.hb = mcc_pkg::HB_WAIT; // [RULE_06]
                    n.hb_cnt = 8'(`MCC_HB_DLY_CYC - 1);
                end
            end
            mcc_pkg::HB_WAIT:
            begin
                if (s.fdx || s.hb_sup)
                begin
                    n.hb = mcc_pkg::HB_IDLE;
                end
                else if (s.hb_cnt == 8'h00)
                begin
                    n.hb = mcc_pkg::HB_PULSE;
                    n.hb_cnt = 8'(`MCC_HB_LEN_CYC - 1);
                end
                else
                begin
                    n.hb_cnt = s.hb_cnt - 8'h01;
                end
            end
            mcc_pkg::HB_PULSE:
            begin
                if (s.fdx || s.hb_sup || s.hb_cnt == 8'h00)
                begin
                    n.hb = mcc_pkg::HB_IDLE;
                end
                else
                begin
                    n.hb_cnt = s.hb_cnt - 8'h01;
                end
            end
            default:
            begin
                n.hb = mcc_pkg::HB_IDLE;
            end
        endcase

        // management frames, one step per management clock rise
        if (mdc_rise) // [RULE_12]
        begin
            unique case (s.md)
                mcc_pkg::MD_IDLE:
                begin
                    if (!mdio_s)
                    begin
                        n.md = mcc_pkg::MD_HDR;
                        n.md_cnt = `MCC_MD_HDR_BITS;
                    end
                end
                mcc_pkg::MD_HDR:
                begin
                    n.md_sr = {s.md_sr[11:0], mdio_s};
                    if (s.md_cnt == 5'h01)
                    begin
                        if (s.md_sr[11] && s.md_sr[10:9] == `MCC_MD_OP_READ
                            && s.md_sr[8:4] == `MCC_PHY_ADDR)
                        begin
                            n.md = mcc_pkg::MD_TA;
                            n.md_dat = ({s.md_sr[3:0], mdio_s}
                                == `MCC_MD_REG_HBT)
                                ? {13'h0000, s.hb_sup, 2'h0} : 16'h0000;
                        end
                        else
                        begin
                            n.md = mcc_pkg::MD_SKIP;
                            n.md_cnt = `MCC_MD_SKIP_BITS;
                        end
                    end
                    else
                    begin
                        n.md_cnt = s.md_cnt - 5'h01;
                    end
                end
                mcc_pkg::MD_TA:
                begin
                    n.md = mcc_pkg::MD_RD;
                    n.md_cnt = `MCC_MD_DATA_BITS;
                    n.mdio_o = 1'b0;
                    n.mdio_oe = 1'b1; // [RULE_11] [RULE_14]
                end
                mcc_pkg::MD_RD:
                begin
                    if (s.md_cnt == 5'h00)
                    begin
                        n.md = mcc_pkg::MD_IDLE;
                        n.mdio_oe = 1'b0; // [RULE_14]
                        n.mdio_o = 1'b0;
                    end
                    else
                    begin
                        n.mdio_o = s.md_dat[15]; // [RULE_11]
                        n.md_dat = {s.md_dat[14:0], 1'b0};
                        n.md_cnt = s.md_cnt - 5'h01;
                    end
                end
                mcc_pkg::MD_SKIP:
                begin
                    if (s.md_cnt == 5'h00)
                    begin
                        n.md = mcc_pkg::MD_IDLE;
                    end
                    else
                    begin
                        n.md_cnt = s.md_cnt - 5'h01;
                    end
                end
                default:
                begin
                    n.md = mcc_pkg::MD_IDLE;
                    n.mdio_oe = 1'b0;
                end
            endcase
        end

        // axi4-lite write: address and data in either order
        if (s_axi_awvalid && s.awready)
        begin
            n.aw_got = 1'b1;
            n.aw_adr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            n.w_got = 1'b1;
            n.w_byte = s_axi_wdata[7:0];
            n.w_be = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `MCC_RESP_OK;
            if ({s.aw_adr[7:2], 2'b00} == adr(`MCC_IDX_CTRL))
            begin
                if (s.w_be)
                begin
                    n.fdx = s.w_byte[`MCC_CTRL_FDX];
                    n.rep = s.w_byte[`MCC_CTRL_REP];
                    n.spd = s.w_byte[`MCC_CTRL_SPD];
                end
            end
            else if ({s.aw_adr[7:2], 2'b00} == adr(`MCC_IDX_HBT))
            begin
                if (s.w_be)
                begin
                    n.hb_sup = s.w_byte[`MCC_HBT_SUP]; // [RULE_06]
                end
            end
            else if ({s.aw_adr[7:2], 2'b00} != adr(`MCC_IDX_STAT))
            begin
                n.bresp = `MCC_RESP_SLVERR;
            end
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // axi4-lite read
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = 32'h0000_0000;
            n.rresp = `MCC_RESP_OK;
            if ({s_axi_araddr[7:2], 2'b00} == adr(`MCC_IDX_CTRL))
            begin
                n.rdata[`MCC_CTRL_FDX] = s.fdx;
                n.rdata[`MCC_CTRL_REP] = s.rep;
                n.rdata[`MCC_CTRL_SPD] = s.spd;
            end
            else if ({s_axi_araddr[7:2], 2'b00} == adr(`MCC_IDX_STAT))
            begin
                n.rdata[`MCC_STAT_COL] = s.col;
                n.rdata[`MCC_STAT_CRS] = s.crs;
                n.rdata[`MCC_STAT_ACT] = act;
                n.rdata[`MCC_STAT_TX] = tx;
            end
            else if ({s_axi_araddr[7:2], 2'b00} == adr(`MCC_IDX_HBT))
            begin
                n.rdata[`MCC_HBT_SUP] = s.hb_sup;
            end
            else
            begin
                n.rresp = `MCC_RESP_SLVERR;
            end
        end
        n.arready = !n.rvalid;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.fdx <= `MCC_CTRL_RST;
            s.rep <= `MCC_CTRL_RST;
            s.spd <= `MCC_CTRL_RST;
            s.hb_sup <= `MCC_HBT_RST;
            s.hb <= mcc_pkg::HB_IDLE;
            s.md <= mcc_pkg::MD_IDLE;
        end
        else
        begin
            s <= n;
        end
    end

    // status outputs, consumers synchronise them [RULE_04] [RULE_09]
    assign col = s.col;
    assign crs = s.crs;
    assign mdio_o = s.mdio_o;
    assign mdio_oe = s.mdio_oe;
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_col_on_overlap: assert property (@(posedge clk) disable iff (!rst_n)
        $past(tx && act && !s.fdx) |-> col) // [RULE_01]
        else $error("collision missing during transmit and receive");

    a_col_fdx_low: assert property (@(posedge clk) disable iff (!rst_n)
        $past(s.fdx) |-> !col) // [RULE_05]
        else $error("collision high in full duplex");

    a_col_hb_only: assert property (@(posedge clk) disable iff (!rst_n)
        col && !$past(tx && act) |->
        $past(s.hb == mcc_pkg::HB_PULSE) && !$past(s.hb_sup)) // [RULE_06]
        else $error("collision without overlap or heartbeat");

    a_col_release: assert property (@(posedge clk) disable iff (!rst_n)
        $past(!(tx && act) && s.hb != mcc_pkg::HB_PULSE) |-> !col) // [RULE_13]
        else $error("collision held after cause ended");

    a_crs_half_tx: assert property (@(posedge clk) disable iff (!rst_n)
        $past(tx && !s.fdx && !s.rep) |-> crs) // [RULE_07]
        else $error("carrier sense missing on transmit");

    a_crs_rx_only: assert property (@(posedge clk) disable iff (!rst_n)
        $past((s.fdx || s.rep) && !act) |-> !crs) // [RULE_08]
        else $error("carrier sense from own transmit");

    a_crs_on_rx: assert property (@(posedge clk) disable iff (!rst_n)
        $past(act) |-> crs) // [RULE_07] [RULE_13]
        else $error("carrier sense missing on receive");

    a_mdio_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
        ($changed(mdio_o) || $changed(mdio_oe)) |-> $past(mdc_rise))
        else $error("management line moved off clock edge"); // [RULE_12]

    a_mdio_rd_only: assert property (@(posedge clk) disable iff (!rst_n)
        mdio_oe |-> s.md == mcc_pkg::MD_RD) // [RULE_14]
        else $error("management driver on outside read data");

    a_mdio_oe_ta: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mdio_oe) |-> $past(s.md == mcc_pkg::MD_TA) && !mdio_o)
        else $error("driver enabled outside turnaround"); // [RULE_11]

endmodule : mcc_top

//--- hw/mcc_map.svh
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MCC_IDX_CTRL 8'h00
`define MCC_IDX_STAT 8'h01
`define MCC_IDX_HBT 8'h12

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define MCC_CTRL_FDX 0
`define MCC_CTRL_REP 1
`define MCC_CTRL_SPD 2
`define MCC_HBT_SUP 2
`define MCC_STAT_COL 0
`define MCC_STAT_CRS 1
`define MCC_STAT_ACT 2
`define MCC_STAT_TX 3
`define MCC_CTRL_RST 1'b0
`define MCC_HBT_RST 1'b0
`define MCC_RESP_OK 2'h0
`define MCC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MCC_CLK_NS 8
`define MCC_HB_DLY_NS 1000
`define MCC_HB_LEN_NS 1000
`define MCC_HB_DLY_CYC ((`MCC_HB_DLY_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_HB_LEN_CYC ((`MCC_HB_LEN_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)

// ----------------------------------------------------------------------
// symbol and management frame layout
// ----------------------------------------------------------------------
`define MCC_SYM_W 10
`define MCC_MD_HDR_BITS 5'h0d
`define MCC_MD_DATA_BITS 5'h10
`define MCC_MD_SKIP_BITS 5'h11
`define MCC_MD_OP_READ 2'h2
`define MCC_MD_REG_HBT 5'h12
`define MCC_PHY_ADDR 5'h01

`endif

//--- hw/mcc_pkg.sv
package mcc_pkg;

    typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_PULSE} mcc_hb_t;

    typedef enum logic [2:0] {MD_IDLE, MD_HDR, MD_TA, MD_RD, MD_SKIP}
        mcc_md_t;

    typedef struct packed {
        logic fdx;
        logic rep;
        logic spd;
        logic hb_sup;
        logic col;
        logic crs;
        logic tx_d;
        logic mdc_d;
        mcc_hb_t hb;
        logic [7:0] hb_cnt;
        mcc_md_t md;
        logic [4:0] md_cnt;
        logic [12:0] md_sr;
        logic [15:0] md_dat;
        logic mdio_o;
        logic mdio_oe;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_adr;
        logic [7:0] w_byte;
        logic w_be;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mcc_state_t;

endpackage : mcc_pkg

//--- hw/mcc_sync.sv
`timescale 1ns/1ns

module mcc_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } mcc_sync_st_t;

    mcc_sync_st_t s;
    mcc_sync_st_t n;

    always_comb
    begin
        n = s;
        n.s1 = d;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign q = s.s2;

endmodule : mcc_sync

//--- hw/mcc_sym_det.sv
`timescale 1ns/1ns
`include "mcc_map.svh"

module mcc_sym_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`MCC_SYM_W-1:0] sym,
    input wire logic sym_vld,
    output logic act
);

    typedef struct packed {
        logic act;
    } mcc_sym_st_t;

    mcc_sym_st_t s;
    mcc_sym_st_t n;

    // two zeros with at least one bit between them
    function automatic logic sep_zeros(input logic [`MCC_SYM_W-1:0] v);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `MCC_SYM_W; i++)
        begin
            for (int j = i + 2; j < `MCC_SYM_W; j++)
            begin
                if (!v[i] && !v[j])
                begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction : sep_zeros

    always_comb
    begin
        n = s;
        if (sym_vld)
        begin
            n.act = sep_zeros(sym); // [RULE_03]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign act = s.act;

    a_sym_act_set: assert property (@(posedge clk) disable iff (!rst_n)
        sym_vld |=> act == $past(sep_zeros(sym)))
        else $error("symbol activity does not follow symbol"); // [RULE_03]

endmodule : mcc_sym_det

//--- verification/mcc_sta_model.sv
`timescale 1ns/1ns

// --------------------------------------------------------------
// station manager: management clock and shared data line
// --------------------------------------------------------------
module mcc_sta_model (
    output logic mdc,
    output logic sm_o,
    output logic sm_oe,
    input wire logic mdio
);
    // clock stands low outside frames
    initial
    begin
        mdc = 1'b0;
        sm_o = 1'b1;
        sm_oe = 1'b0;
    end

    // data set while clock low, sampled at its rise
    task automatic bit_cyc(input logic v, input logic oe, output logic s);
        sm_o = v;
        sm_oe = oe;
        #80;
        mdc = 1'b1;
        s = mdio;
        #80;
        mdc = 1'b0;
    endtask : bit_cyc

    // read frame; bit 16 of d is the second turnaround bit
    task automatic rd(input logic [4:0] phy, input logic [4:0] rg,
                      output logic [16:0] d);
        logic [17:0] hdr;
        logic s;
        hdr = {4'hf, 2'b01, 2'b10, phy, rg};
        for (int i = 17; i >= 0; i--)
            bit_cyc(hdr[i], 1'b1, s);
        // released from turnaround on
        bit_cyc(1'b1, 1'b0, s);
        for (int i = 16; i >= 0; i--)
        begin
            bit_cyc(1'b1, 1'b0, s);
            d[i] = s;
        end
        bit_cyc(1'b1, 1'b0, s);
        bit_cyc(1'b1, 1'b0, s);
    endtask : rd
endmodule : mcc_sta_model

//--- verification/tb_mcc_top.sv
`timescale 1ns/1ns

module tb_mcc_top;
    logic clk, rst_n, tx_en, rx_unsq_act, rx_sym_vld, col, crs;
    logic [9:0] rx_sym, sy;
    logic mdc, mdio, mdio_o, mdio_oe, sm_o, sm_oe;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rv, r;
    logic [1:0] bresp, rresp, rs;
    logic [16:0] md;
    logic ea, ec, es;
    int num_errors = 0;
    int num_checks = 0;
    int n, early;

    // pull-up when nobody drives
    assign mdio = mdio_oe ? mdio_o : (sm_oe ? sm_o : 1'b1);

    mcc_top mcc_top_i (.clk(clk), .rst_n(rst_n), .tx_en(tx_en),
        .rx_unsq_act(rx_unsq_act), .rx_sym(rx_sym),
        .rx_sym_vld(rx_sym_vld), .col(col), .crs(crs), .mdc(mdc),
        .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    mcc_sta_model mcc_sta_model_i (.mdc(mdc), .sm_o(sm_o),
        .sm_oe(sm_oe), .mdio(mdio));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] b);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        b = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] s);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        s = rresp;
        rready <= 1'b0;
    endtask : axr

    // symbol active if two zeros lie at least two places apart
    function automatic logic sym_act(input logic [9:0] s);
        int lo = 10;
        int hi = -1;
        for (int i = 0; i < 10; i++)
        begin
            if (!s[i] && lo == 10) lo = i;
            if (!s[i]) hi = i;
        end
        return (hi - lo) >= 2;
    endfunction : sym_act

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #400000;
        num_errors++;
        print_verdict();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        {rst_n, tx_en, rx_unsq_act, rx_sym_vld} = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, rx_sym} = {16'h0, 32'h0, 10'h3ff};
        r = $urandom(32'hcb36);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axr(8'h00, rv, rs);
        chk("ctrl_rst", 32'h0, rv);
        axr(8'h48, rv, rs);
        chk("hbt_rst", 32'h0, rv);
        axr(8'h10, rv, rs);
        chk("unmap_rresp", 32'h2, {30'h0, rs});
        axw(8'h10, 32'h1, rs);
        chk("unmap_bresp", 32'h2, {30'h0, rs});
        axw(8'h04, 32'hf, rs);
        chk("stat_bresp", 32'h0, {30'h0, rs});
        axw(8'h48, 32'h4, rs);
        axr(8'h48, rv, rs);
        chk("hbt_rb", 32'h4, rv);
        $display("test registers done");

        // random mode, transmit and receive activity
        for (int k = 0; k < 48; k++)
        begin
            r = $urandom;
            // first draws step through every mode
            if (k < 8) r[2:0] = k[2:0];
            sy = ~((10'h1 << (r[11:8] % 10)) | (10'h1 << (r[15:12] % 10)));
            axw(8'h00, {29'h0, r[2:0]}, rs);
            tx_en <= r[3];
            rx_unsq_act <= r[4];
            rx_sym <= sy;
            rx_sym_vld <= 1'b1;
            @(posedge clk);
            rx_sym_vld <= 1'b0;
            repeat (8) @(posedge clk);
            ea = r[2] ? sym_act(sy) : r[4];
            ec = !r[0] && r[3] && ea;
            es = ea || (r[3] && !r[0] && !r[1]);
            chk("col", {31'h0, ec}, {31'h0, col});
            chk("crs", {31'h0, es}, {31'h0, crs});
            axr(8'h04, rv, rs);
            chk("stat", {28'h0, r[3], ea, es, ec}, rv);
        end
        $display("test link modes done");

        // heartbeat: plain, suppressed, full duplex
        rx_unsq_act <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            axw(8'h48, (k == 1) ? 32'h4 : 32'h0, rs);
            axw(8'h00, (k == 2) ? 32'h1 : 32'h0, rs);
            tx_en <= 1'b1;
            repeat (10) @(posedge clk);
            tx_en <= 1'b0;
            n = 0;
            early = 0;
            for (int i = 0; i < 420; i++)
            begin
                @(posedge clk);
                if (col === 1'b1) n++;
                if (col === 1'b1 && i < 120) early++;
            end
            chk("hb_early", 32'h0, early);
            chk("hb_len", (k == 0) ? 32'd125 : 32'd0, n);
        end
        $display("test heartbeat done");

        // management reads
        axw(8'h48, 32'h4, rs);
        mcc_sta_model_i.rd(5'h01, 5'h12, md);
        chk("md_sup1", 32'h00004, {15'h0, md});
        axw(8'h48, 32'h0, rs);
        mcc_sta_model_i.rd(5'h01, 5'h12, md);
        chk("md_sup0", 32'h00000, {15'h0, md});
        mcc_sta_model_i.rd(5'h02, 5'h12, md);
        chk("md_other", 32'h1ffff, {15'h0, md});
        mcc_sta_model_i.rd(5'h01, 5'h03, md);
        chk("md_reg3", 32'h00000, {15'h0, md});
        chk("md_oe_idle", 32'h0, {31'h0, mdio_oe});
        $display("test management done");
        print_verdict();
    end
endmodule : tb_mcc_top
